// ==== rtl/sas_slave.sv ====
/*
  Serial management bus slave front end with strap address selection,
  byte framing, acknowledge and a write FIFO toward the register file.
  Assumes scl and sda pins arrive asynchronously and the register file
  shares the block clock.
*/
`timescale 1ns/1ps

module sas_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  import sas_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [CW-1:0]               count;
    logic                        head_valid;
    logic [WIDTH-1:0]            head;
  } sas_fifo_state_t;

  sas_fifo_state_t s;
  sas_fifo_state_t next_s;
  logic            do_push;
  logic            do_pop;

  always_comb begin
    next_s  = s;
    do_push = in_valid && (s.count != FULL);
    do_pop  = out_ready && (s.count != '0);
    if (do_push) begin
      next_s.mem[s.wr] = in_data;
      next_s.wr        = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
    end
    if (do_pop) begin
      next_s.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
    end
    if (do_push && !do_pop) begin
      next_s.count = s.count + 1'b1;
    end else if (do_pop && !do_push) begin
      next_s.count = s.count - 1'b1;
    end
    // Head and its flag are registered so the drain side sees flop outputs
    next_s.head_valid = (next_s.count != '0);
    next_s.head       = next_s.mem[next_s.rd];
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign in_ready  = (s.count != FULL);
  assign out_valid = s.head_valid;
  assign out_data  = s.head;

endmodule

module sas_slave #(
  parameter bit FIXED_ADDRESS = 1'b0,
  parameter int FIFO_DEPTH    = 8
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // Serial bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Address straps
  input  wire logic       address_enable_strap,
  input  wire logic       address_choice_pin,
  // Register file side
  output logic [7:0]      pointer,
  input  wire logic [7:0] read_data,
  output logic            wr_valid,
  input  wire logic       wr_ready,
  output sas_pkg::sas_wr_t wr_data,
  // Status
  output logic [6:0]      slave_address,
  output logic            address_locked
);
  import sas_pkg::*;

  typedef struct packed {
    logic       scl_m, scl_s, scl_p;
    logic       sda_m, sda_s, sda_p;
    logic       ena_m, ena_s, sel_m, sel_s;
    logic [1:0] boot;
    logic [6:0] addr;
    logic       locked;
    sas_state_t st;
    logic [3:0] bits;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [1:0] idx;
    logic       match;
    logic       oe;
    logic [7:0] pointer;
    logic       push;
    sas_wr_t    push_data;
  } sas_state_vec_t;

  sas_state_vec_t s;
  sas_state_vec_t next_s;
  logic           fifo_ready;
  logic           rise;
  logic           fall;
  logic           start_c;
  logic           stop_c;

  function automatic logic [6:0] strap_address(input logic ena, input logic sel);
    if (FIXED_ADDRESS || ena) begin
      strap_address = SAS_ADDR_DEFAULT;
    end else begin
      strap_address = sel ? SAS_ADDR_CHOICE1 : SAS_ADDR_CHOICE0;
    end
  endfunction

  always_comb begin
    next_s       = s;
    next_s.push  = 1'b0;
    next_s.scl_m = scl_in;
    next_s.scl_s = s.scl_m;
    next_s.scl_p = s.scl_s;
    next_s.sda_m = sda_in;
    next_s.sda_s = s.sda_m;
    next_s.sda_p = s.sda_s;
    next_s.ena_m = address_enable_strap;
    next_s.ena_s = s.ena_m;
    next_s.sel_m = address_choice_pin;
    next_s.sel_s = s.sel_m;
    rise    = s.scl_s && !s.scl_p;
    fall    = !s.scl_s && s.scl_p;
    start_c = s.scl_s && s.scl_p && s.sda_p && !s.sda_s;
    stop_c  = s.scl_s && s.scl_p && !s.sda_p && s.sda_s;

    // Straps are sampled once the synchronisers have settled after power-up
    if (s.boot != SAS_BOOT_CYCLES) begin
      next_s.boot = s.boot + 1'b1;
      if (s.boot == SAS_BOOT_CYCLES - 2'h1) begin
        next_s.addr = strap_address(s.ena_s, s.sel_s);
      end
    end

    if (stop_c) begin
      next_s.st = SAS_IDLE;
      next_s.oe = 1'b0;
    end else if (start_c) begin
      next_s.st    = SAS_ADDR;                              // repeated start too
      next_s.bits  = '0;
      next_s.idx   = '0;
      next_s.match = 1'b0;
      next_s.oe    = 1'b0;
    end else if (rise) begin
      // Our own acknowledge must not push the R/W bit out of the shifter
      if (s.st != SAS_IDLE && s.st != SAS_IGNORE && s.st != SAS_ACK_ADDR) begin
        next_s.shift = {s.shift[6:0], s.sda_s};            // MSB first
        next_s.bits  = s.bits + 1'b1;
      end
      if (s.st == SAS_ADDR && s.bits == SAS_ADDR_BITS) begin
        next_s.match = (s.shift[6:0] == s.addr);
        if (s.shift[6:0] == s.addr && !s.locked) begin
          next_s.locked = 1'b1;
        end
      end
    end else if (fall) begin
      unique case (s.st)
        SAS_IDLE, SAS_IGNORE: begin
          next_s.oe = 1'b0;
        end
        SAS_ADDR: begin
          if (s.bits == SAS_BYTE_BITS) begin
            if (s.match) begin
              next_s.st = SAS_ACK_ADDR;
              next_s.oe = 1'b1;
            end else begin
              next_s.st = SAS_IGNORE;
            end
          end
        end
        SAS_ACK_ADDR: begin
          next_s.bits = '0;
          if (s.shift[0]) begin
            next_s.st = SAS_TX;
            next_s.tx = read_data;
            next_s.oe = !read_data[7];
          end else begin
            next_s.st = SAS_RX;
            next_s.oe = 1'b0;
          end
        end
        SAS_RX: begin
          if (s.bits == SAS_BYTE_BITS) begin
            next_s.st = SAS_ACK_RX;
            if (s.idx == 2'h0) begin
              next_s.pointer = s.shift;
              next_s.oe      = 1'b1;
            end else if (s.idx == 2'h1 && fifo_ready) begin
              next_s.push      = 1'b1;
              next_s.push_data = '{reg_addr: s.pointer, data: s.shift};
              next_s.oe        = 1'b1;
            end else begin
              // No room or a third byte: no acknowledge
              next_s.oe = 1'b0;
            end
          end
        end
        SAS_ACK_RX: begin
          next_s.st   = SAS_RX;
          next_s.bits = '0;
          next_s.oe   = 1'b0;
          if (s.idx != 2'h3) begin
            next_s.idx = s.idx + 1'b1;
          end
        end
        SAS_TX: begin
          if (s.bits == SAS_BYTE_BITS) begin
            next_s.st = SAS_ACK_TX;
            next_s.oe = 1'b0;
          end else begin
            next_s.oe = !s.tx[3'(4'h7 - s.bits)];           // change while low
          end
        end
        SAS_ACK_TX: begin
          next_s.bits = '0;
          if (s.shift[0]) begin
            next_s.st = SAS_IGNORE;
            next_s.oe = 1'b0;
          end else begin
            // Master asked for more: the same register again
            next_s.st = SAS_TX;
            next_s.tx = read_data;
            next_s.oe = !read_data[7];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s         <= '0;
      s.addr    <= SAS_ADDR_DEFAULT;
      s.pointer <= SAS_POINTER_RST;
      s.scl_m   <= 1'b1;
      s.scl_s   <= 1'b1;
      s.scl_p   <= 1'b1;
      s.sda_m   <= 1'b1;
      s.sda_s   <= 1'b1;
      s.sda_p   <= 1'b1;
      s.st      <= SAS_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Back-pressure: a full FIFO turns into a missing acknowledge
  sas_fifo #(
    .WIDTH ($bits(sas_wr_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (s.push),
    .in_ready  (fifo_ready),
    .in_data   (s.push_data),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_data)
  );

  assign sda_out        = 1'b0;
  assign sda_oe         = s.oe;
  assign pointer        = s.pointer;
  assign slave_address  = s.addr;
  assign address_locked = s.locked;

endmodule

// ==== rtl/sas_pkg.sv ====
/*
  Constants and types of the management bus slave front end.
  Assumes a single 200 MHz clock and asynchronous active-high reset.
*/
// How it works
// - Slave only; all control through bus transactions
// - Fixed variant answers only address 0101110
// - Enable strap high gives address 0x2E
// - Enable strap low selects address choice mode
// - Choice pin low 0101100, high 0101101
// - Straps sampled at power-up form the address
// - Address latched at eighth rise, first match
// - Later strap changes ignored until power-up
// - Nine pulses per byte, MSB first, ack
// - Data changes in clock low; rise-high is stop
// - Protocol sets no bound on byte count
// - First write byte pointer, second into register
// - Writes one or two bytes, reads one; code resends the same register while the master acks
package sas_pkg;

  localparam logic [6:0] SAS_ADDR_DEFAULT = 7'h2e;
  localparam logic [6:0] SAS_ADDR_CHOICE0 = 7'h2c;
  localparam logic [6:0] SAS_ADDR_CHOICE1 = 7'h2d;
  localparam logic [1:0] SAS_BOOT_CYCLES  = 2'h3;
  localparam logic [3:0] SAS_ADDR_BITS    = 4'h7;
  localparam logic [3:0] SAS_BYTE_BITS    = 4'h8;
  localparam logic [7:0] SAS_POINTER_RST  = 8'h00;

  typedef enum logic [2:0] {
    SAS_IDLE     = 3'b000,
    SAS_ADDR     = 3'b001,
    SAS_ACK_ADDR = 3'b010,
    SAS_RX       = 3'b011,
    SAS_ACK_RX   = 3'b100,
    SAS_TX       = 3'b101,
    SAS_ACK_TX   = 3'b110,
    SAS_IGNORE   = 3'b111
  } sas_state_t;

  typedef struct packed {
    logic [7:0] reg_addr;
    logic [7:0] data;
  } sas_wr_t;

endpackage

// ==== testbench/sas_slave_asserts.sv ====
/*
  Port checker for the bus slave front end.
  Assumes binding to sas_slave and a single clock domain.
*/
`timescale 1ns/1ps
module sas_slave_asserts (
  // Clock and reset
  input wire logic             clock,
  input wire logic             reset,
  // Bus and status
  input wire logic             scl_in,
  input wire logic             sda_oe,
  input wire logic [7:0]       pointer,
  input wire logic             wr_valid,
  input wire logic             wr_ready,
  input wire sas_pkg::sas_wr_t wr_data,
  input wire logic [6:0]       slave_address,
  input wire logic             address_locked
);
  import sas_pkg::*;
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  AST_ACK_IN_LOW: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in, 3))
    else $error("data pulled while clock high");
  AST_OE_HELD_HIGH: assert property (sda_oe && scl_in |=> sda_oe)
    else $error("data released while clock high");
  AST_LOCK_STICKY: assert property (address_locked |=> address_locked)
    else $error("lock flag dropped");
  AST_ADDR_FROZEN: assert property (address_locked |=> $stable(slave_address))
    else $error("address moved after lock");
  AST_ADDR_LEGAL: assert property (slave_address inside {7'h2c, 7'h2d, 7'h2e})
    else $error("illegal slave address");
  AST_LOCK_SCL_HIGH: assert property ($rose(address_locked) |-> scl_in && $past(scl_in))
    else $error("lock outside clock high");
  AST_LOCK_ACK: assert property ($rose(address_locked) |-> ##[1:30] sda_oe)
    else $error("no ack after lock");
  AST_PTR_AT_FALL: assert property ($changed(pointer) |-> !scl_in)
    else $error("pointer moved in clock high");
  AST_WR_HOLD: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
    else $error("write head not held");
endmodule
bind sas_slave sas_slave_asserts u_sas_slave_asserts (
  .clock(clock), .reset(reset), .scl_in(scl_in), .sda_oe(sda_oe), .pointer(pointer),
  .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
  .slave_address(slave_address), .address_locked(address_locked)
);

// ==== testbench/sas_master.sv ====
/*
  Bus master model: makes the serial clock, drives data open drain.
  Assumes the bench models the data pull-up.
*/
`timescale 1ns/1ps
module sas_master (
  // Clock and bus
  input  wire logic clock,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Data moves only in clock low; 25 cycles make 125 ns
  task automatic bit_io(input logic b, output logic r);
    wt(6);
    sda_oe <= ~b;
    wt(6);
    scl <= 1'b1;
    wt(6);
    r = sda;
    wt(7);
    scl <= 1'b0;
  endtask
  // Also serves as repeated start
  task automatic start;
    sda_oe <= 1'b0;
    wt(6);
    scl <= 1'b1;
    wt(6);
    sda_oe <= 1'b1;
    wt(6);
    scl <= 1'b0;
  endtask
  // Low before the tenth rise, released while high
  task automatic stop;
    wt(6);
    sda_oe <= 1'b1;
    wt(6);
    scl <= 1'b1;
    wt(6);
    sda_oe <= 1'b0;
    wt(12);
  endtask
  // MSB first, ninth slot acked by mack; no ack means no-acknowledge
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(~mack, r);
    ack = ~r;
  endtask
endmodule

// ==== testbench/sas_slave_test.sv ====
/*
  Self-checking bench of the bus slave front end.
  Assumes the master model and checker are compiled alongside.
*/
`timescale 1ns/1ps
module sas_slave_test;
  import sas_pkg::*;
  logic        clock = 1'b0, reset = 1'b1, en_strap = 1'b1, choice = 1'b0;
  logic        wr_ready = 1'b0, hold = 1'b1, sda_oe, sda_out, m_oe, scl, wr_valid, lock, ack;
  logic        fx_oe, fx_lock;
  logic [6:0]  fx_addr;
  logic [7:0]  read_data = 8'h00, pointer, q, exp_ptr;
  logic [6:0]  slave_address, exp_addr;
  logic [31:0] seed = 32'h5461e395;
  logic [15:0] exp_q[$];
  sas_wr_t     wr_data;
  int          fail_count = 0, n_compared = 0;
  wire         sda = (sda_oe ? sda_out : 1'b1) & ~m_oe & ~fx_oe;
  always #2.5 clock = ~clock;
  sas_slave u_sas_slave (.clock(clock), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .address_enable_strap(en_strap),
    .address_choice_pin(choice), .pointer(pointer), .read_data(read_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .slave_address(slave_address), .address_locked(lock));
  // Fixed variant shares the bus; it answers exactly like the main one at 0x2e
  sas_slave #(.FIXED_ADDRESS(1'b1)) u_sas_slave_fixed (.clock(clock), .reset(reset),
    .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(fx_oe), .address_enable_strap(en_strap),
    .address_choice_pin(choice), .pointer(), .read_data(read_data), .wr_valid(),
    .wr_ready(wr_ready), .wr_data(), .slave_address(fx_addr), .address_locked(fx_lock));
  sas_master u_sas_master (.clock(clock), .sda(sda), .scl(scl), .sda_oe(m_oe));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Register file stand-in; consumer stalls at random
  always @(posedge clock) begin
    read_data <= pointer ^ 8'ha5;
    seed <= lfsr(seed);
    wr_ready <= hold ? 1'b0 : seed[0];
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      check(wr_data, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
  end
  task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic two, input logic full);
    u_sas_master.start;
    u_sas_master.xfer({exp_addr, 1'b0}, 1'b0, q, ack);
    check(ack, 1'b1);
    u_sas_master.xfer(p, 1'b0, q, ack);
    exp_ptr = p;
    check(ack, 1'b1);
    if (two) begin
      if (!full) exp_q.push_back({p, d});
      u_sas_master.xfer(d, 1'b0, q, ack);
      check(ack, !full);
      u_sas_master.xfer(d, 1'b0, q, ack);
      check(ack, 1'b0);
      u_sas_master.stop;
    end
  endtask
  // Pointer-only writes end in a repeated start here
  task automatic rd(input logic mack);
    check(pointer, exp_ptr);
    u_sas_master.start;
    u_sas_master.xfer({exp_addr, 1'b1}, 1'b0, q, ack);
    check(ack, 1'b1);
    u_sas_master.xfer(8'hff, mack, q, ack);
    check(q, exp_ptr ^ 8'ha5);
    if (mack) begin
      u_sas_master.xfer(8'hff, 1'b0, q, ack);
      check(q, exp_ptr ^ 8'ha5);
    end
    u_sas_master.stop;
  endtask
  initial begin
    for (int k = 0; k < 3; k++) begin
      en_strap <= (k == 2);
      choice <= (k == 1);
      reset <= 1'b1;
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      repeat (8) @(posedge clock);
      exp_q.delete();
      exp_addr = (k == 2) ? 7'h2e : ((k == 1) ? 7'h2d : 7'h2c);
      check(slave_address, exp_addr);
      check(fx_addr, 7'h2e);
      u_sas_master.start;
      u_sas_master.xfer({exp_addr ^ 7'h01, 1'b0}, 1'b0, q, ack);
      check(ack, 1'b0);
      u_sas_master.xfer(8'h00, 1'b0, q, ack);
      check(ack, 1'b0);
      u_sas_master.stop;
      check(lock, 1'b0);
      hold <= 1'b0;
      wr(seed[15:8], seed[7:0], 1'b1, 1'b0);
      check(lock, 1'b1);
      check(fx_lock, k == 2);
      en_strap <= ~en_strap;
      choice <= ~choice;
      rd(k[0]);
      wr(seed[23:16], 8'h00, 1'b0, 1'b0);
      rd(1'b0);
      check(slave_address, exp_addr);
    end
    // Fill the FIFO with the consumer stalled; the ninth entry is refused
    hold <= 1'b1;
    for (int i = 0; i < 9; i++) wr(8'(i), seed[7:0], 1'b1, i == 8);
    hold <= 1'b0;
    for (int n = 0; n < 2000 && exp_q.size() > 0; n++) @(posedge clock);
    check(exp_q.size(), 16'h0000);
    wrap_up;
  end
  initial begin
    #200000;
    fail_count++;
    wrap_up;
  end
endmodule
